// File: ipx_top.sv
// Interrupt controller with peripheral event channels, traps and external source select
`timescale 1ns/1ps
`include "ipx_params.svh"

// Function
// RL1 - A request is offered to the CPU no sooner than 125 ns and no later than 300 ns after it is flagged.
// RL2 - A standard service hands the CPU the dedicated vector number of the requesting source.
// RL3 - An event channel service takes one single cycle and moves one byte or word between two addresses.
// RL4 - Each channel service advances either the source or the destination pointer as configured.
// RL5 - The channel count drops by one per service and stays unchanged in continuous mode.
// RL6 - A request whose channel count is zero is served as a standard interrupt of that source instead; in continuous mode the code runs the channel service.
// RL7 - There are eight independent event channels, each triggered by an interrupt request.
// RL8 - Each source has a control register with a request flag, an enable flag and a four-bit level.
// RL9 - Only a request with level strictly above the running level is taken; others stay pending.
// RL10 - A trap request with its own number is offered to the CPU as the vector to take.
// RL11 - Each external input detects rising, falling or both edges as programmed.
// RL12 - The two-bit source field picks pin, alternate source, their OR or their AND.
// RL13 - External channels 0 to 7 use their pins; the alternates are the two CAN receive lines then zero.
// RL14 - Pin and alternate are combined after synchronisation and the select register resets to zero.
module ipx_top
  import ipx_pkg::*;
#(
  parameter int NUM_SRC = 16,
  parameter int NUM_PEC = 8,
  parameter int PTR_W   = 24
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [17:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // External interrupt pins
  input  wire logic [7:0]         ext_int_pin,
  input  wire logic               first_can_receive_line,
  input  wire logic               second_can_receive_line,
  // Peripheral requests
  input  wire logic [NUM_SRC-1:0] src_req,
  // CPU side
  input  wire logic [3:0]         cpu_level,
  input  wire logic               trap_req,
  input  wire logic [6:0]         trap_num,
  input  wire logic               vec_ack,
  output logic                    vec_valid,
  output logic      [6:0]         vec_num,
  output logic      [3:0]         vec_level,
  output logic                    vec_trap,
  // Event channel transfer
  output logic                    pec_valid,
  output logic      [2:0]         pec_chan,
  output logic      [PTR_W-1:0]   pec_src_addr,
  output logic      [PTR_W-1:0]   pec_dst_addr,
  output logic                    pec_word,
  // Interrupt line
  output logic                    irq
);

  localparam int SIW = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
  localparam int CIW = 3;
  localparam int MIN_CYC = `IPX_RESP_MIN_CYC;
  localparam int MAX_CYC = `IPX_RESP_MAX_CYC;
  localparam logic [5:0] WAIT_LAST = 6'(MIN_CYC - 1);
  localparam logic [PTR_W-1:0] STEP_BYTE = PTR_W'(1);
  localparam logic [PTR_W-1:0] STEP_WORD = PTR_W'(2);

  if (NUM_SRC < 8 || NUM_SRC > 128) begin : g_bad_src
    $error("NUM_SRC must lie in 8..128");
  end
  if (NUM_PEC != 8) begin : g_bad_pec
    $error("NUM_PEC must be 8");
  end
  if (PTR_W < 2 || PTR_W > 32) begin : g_bad_ptr
    $error("PTR_W must lie in 2..32");
  end
  if (MIN_CYC < 2 || MIN_CYC > MAX_CYC || MIN_CYC > 63) begin : g_bad_time
    $error("Response window does not fit the wait counter");
  end

  function automatic logic in_range(input logic [15:0] idx, input logic [15:0] base, input int unsigned n);
    return (32'(idx) >= 32'(base)) && (32'(idx) < 32'(base) + n);
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [15:0]        src_sel;
  logic [15:0]        edge_mode;
  logic [15:0]        status;
  logic [15:0]        mask;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] en;
  logic [3:0]         lvl      [NUM_SRC];
  logic [7:0]         pc_cnt   [NUM_PEC];
  logic               pc_wrd   [NUM_PEC];
  logic               pc_incd  [NUM_PEC];
  logic               pc_cont  [NUM_PEC];
  logic               pc_en    [NUM_PEC];
  logic [7:0]         pc_src   [NUM_PEC];
  logic [PTR_W-1:0]   pc_sp    [NUM_PEC];
  logic [PTR_W-1:0]   pc_dp    [NUM_PEC];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic [15:0]    reg_idx  = paddr[17:2];
  wire logic [15:0]    src_off  = reg_idx - `IPX_IDX_SRC_BASE;
  wire logic [15:0]    pec_off  = reg_idx - `IPX_IDX_PEC_BASE;
  wire logic [SIW-1:0] src_idx  = src_off[SIW-1:0];
  wire logic [CIW-1:0] pec_ch   = pec_off[CIW+1:2];
  wire logic [1:0]     pec_fld  = pec_off[1:0];
  wire logic           hit_sel  = reg_idx == `IPX_IDX_SRC_SEL;
  wire logic           hit_edge = reg_idx == `IPX_IDX_EDGE_MODE;
  wire logic           hit_stat = reg_idx == `IPX_IDX_STATUS;
  wire logic           hit_mask = reg_idx == `IPX_IDX_MASK;
  wire logic           hit_src  = in_range(reg_idx, `IPX_IDX_SRC_BASE, NUM_SRC);
  wire logic           hit_pec  = in_range(reg_idx, `IPX_IDX_PEC_BASE, 4 * NUM_PEC) && (pec_fld != 2'h3);
  wire logic           hit_any  = hit_sel | hit_edge | hit_stat | hit_mask | hit_src | hit_pec;
  wire logic           access   = psel & penable;
  wire logic           wr_en    = access & pready & pwrite & hit_any;
  wire logic           wr_src   = wr_en & hit_src;
  wire logic           wr_pec   = wr_en & hit_pec;

  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_sel) begin
      rd_data = {16'h0000, src_sel};
    end else if (hit_edge) begin
      rd_data = {16'h0000, edge_mode};
    end else if (hit_stat) begin
      rd_data = {16'h0000, status};
    end else if (hit_mask) begin
      rd_data = {16'h0000, mask};
    end else if (hit_src) begin
      rd_data = {24'h00_0000, req[src_idx], en[src_idx], 2'h0, lvl[src_idx]}; // [RL8]
    end else if (hit_pec) begin
      case (pec_fld)
        `IPX_PEC_FLD_CTRL: rd_data = {8'h00, pc_src[pec_ch], 4'h0, pc_en[pec_ch], pc_cont[pec_ch],
                                      pc_incd[pec_ch], pc_wrd[pec_ch], pc_cnt[pec_ch]};
        `IPX_PEC_FLD_SRCP: rd_data = 32'(pc_sp[pec_ch]);
        `IPX_PEC_FLD_DSTP: rd_data = 32'(pc_dp[pec_ch]);
        default:           rd_data = 32'h0000_0000;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hit_any;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // ****************************************************************
  // External inputs
  // ****************************************************************
  logic [7:0] ext_edge;

  ipx_ext_sel #(
    .NUM_CH     (8)
  ) u_ext (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (ext_int_pin),
    .alt        ({6'h00, second_can_receive_line, first_can_receive_line}), // [RL13]
    .src_sel    (src_sel),
    .edge_mode  (edge_mode),
    .edge_pulse (ext_edge)
  );

  wire logic [NUM_SRC-1:0] req_set = src_req | {{(NUM_SRC-8){1'b0}}, ext_edge};

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  logic           best_found;
  logic [SIW-1:0] best_idx;
  logic [3:0]     best_lvl;
  logic           pec_any;
  logic [CIW-1:0] pec_sel;

  // Strict compare keeps the lowest index on equal levels
  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_lvl   = cpu_level;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && en[i] && (lvl[i] > best_lvl)) begin // [RL9]
        best_found = 1'b1;
        best_lvl   = lvl[i];
        best_idx   = SIW'(i);
      end
    end
  end

  always_comb begin
    pec_any = 1'b0;
    pec_sel = '0;
    for (int c = NUM_PEC - 1; c >= 0; c--) begin
      if (pc_en[c] && (pc_src[c] == 8'(best_idx))) begin // [RL7]
        pec_any = 1'b1;
        pec_sel = CIW'(c);
      end
    end
  end

  // ****************************************************************
  // Service sequencing
  // ****************************************************************
  ipx_state_e     state;
  ipx_state_e     next_state;
  logic [5:0]     wait_cnt;
  logic [SIW-1:0] cur_idx;
  logic           trap_pend;
  logic [6:0]     trap_hold;

  wire logic idle      = state == IPX_IDLE;
  wire logic can_pec   = (pc_cnt[pec_sel] != 8'h00) | pc_cont[pec_sel];
  wire logic pec_go    = idle & ~trap_pend & best_found & pec_any & can_pec; // [RL6]
  wire logic take_trap = idle & trap_pend;
  wire logic take_std  = idle & ~trap_pend & best_found & ~pec_go;
  wire logic cur_live  = req[cur_idx] & en[cur_idx];
  wire logic offer_now = (state == IPX_WAIT) & cur_live & (wait_cnt == WAIT_LAST);
  wire logic acked     = (state == IPX_OFFER) & vec_ack;
  wire logic pec_zero  = pec_go & ~pc_cont[pec_sel] & (pc_cnt[pec_sel] == 8'h01);

  always_comb begin
    next_state = state;
    case (state)
      IPX_IDLE:  next_state = take_trap ? IPX_OFFER : (take_std ? IPX_WAIT : IPX_IDLE);
      IPX_WAIT:  next_state = !cur_live ? IPX_IDLE : (offer_now ? IPX_OFFER : IPX_WAIT);
      IPX_OFFER: next_state = vec_ack ? IPX_IDLE : IPX_OFFER;
      default:   next_state = IPX_IDLE;
    endcase
  end

  logic [NUM_SRC-1:0] req_clr;
  always_comb begin
    req_clr = '0;
    if (pec_go) begin
      req_clr[best_idx] = 1'b1;
    end
    if (acked && !vec_trap) begin
      req_clr[cur_idx] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= IPX_IDLE;
      wait_cnt  <= 6'h00;
      cur_idx   <= '0;
      vec_valid <= 1'b0;
      vec_num   <= 7'h00;
      vec_level <= 4'h0;
      vec_trap  <= 1'b0;
    end else begin
      state    <= next_state;
      wait_cnt <= take_std ? 6'h01 : wait_cnt + 6'h01; // [RL1]
      if (take_std) begin
        cur_idx <= best_idx;
      end
      if (take_trap) begin
        vec_valid <= 1'b1;
        vec_num   <= trap_hold; // [RL10]
        vec_level <= `IPX_TRAP_LEVEL;
        vec_trap  <= 1'b1;
      end else if (offer_now) begin
        vec_valid <= 1'b1;
        vec_num   <= 7'(cur_idx); // [RL2]
        vec_level <= lvl[cur_idx];
        vec_trap  <= 1'b0;
      end else if (acked) begin
        vec_valid <= 1'b0;
      end
    end
  end

  // A trap that arrives during its own acknowledge stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pend <= 1'b0;
      trap_hold <= 7'h00;
    end else begin
      trap_pend <= trap_req | (trap_pend & ~(acked & vec_trap));
      if (trap_req) begin
        trap_hold <= trap_num;
      end
    end
  end

  // ****************************************************************
  // Source control registers; hardware set wins over any clear
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
      en  <= '0;
      for (int i = 0; i < NUM_SRC; i++) begin
        lvl[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (req_set[i]) begin
          req[i] <= 1'b1;
        end else if (wr_src && (src_idx == SIW'(i))) begin
          req[i] <= pwdata[`IPX_CTRL_REQ]; // [RL8]
        end else if (req_clr[i]) begin
          req[i] <= 1'b0;
        end
        if (wr_src && (src_idx == SIW'(i))) begin
          en[i]  <= pwdata[`IPX_CTRL_EN];
          lvl[i] <= pwdata[`IPX_CTRL_LVL_MSB:0];
        end
      end
    end
  end

  // ****************************************************************
  // Event channels
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_PEC; c++) begin
        pc_cnt[c]  <= 8'h00;
        pc_wrd[c]  <= 1'b0;
        pc_incd[c] <= 1'b0;
        pc_cont[c] <= 1'b0;
        pc_en[c]   <= 1'b0;
        pc_src[c]  <= 8'h00;
        pc_sp[c]   <= '0;
        pc_dp[c]   <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_PEC; c++) begin
        if (wr_pec && (pec_ch == CIW'(c))) begin
          case (pec_fld)
            `IPX_PEC_FLD_CTRL: begin
              pc_cnt[c]  <= pwdata[`IPX_PEC_CNT_MSB:0];
              pc_wrd[c]  <= pwdata[`IPX_PEC_WORD];
              pc_incd[c] <= pwdata[`IPX_PEC_INC_DST];
              pc_cont[c] <= pwdata[`IPX_PEC_CONT];
              pc_en[c]   <= pwdata[`IPX_PEC_EN];
              pc_src[c]  <= pwdata[`IPX_PEC_SRC_MSB:`IPX_PEC_SRC_LSB];
            end
            `IPX_PEC_FLD_SRCP: pc_sp[c] <= pwdata[PTR_W-1:0];
            `IPX_PEC_FLD_DSTP: pc_dp[c] <= pwdata[PTR_W-1:0];
            default: ;
          endcase
        end
        // The transfer's own update overrides a same-cycle software write
        if (pec_go && (pec_sel == CIW'(c))) begin
          if (!pc_cont[c]) begin
            pc_cnt[c] <= pc_cnt[c] - 8'h01; // [RL5]
          end
          if (pc_incd[c]) begin
            pc_dp[c] <= pc_dp[c] + (pc_wrd[c] ? STEP_WORD : STEP_BYTE); // [RL4]
          end else begin
            pc_sp[c] <= pc_sp[c] + (pc_wrd[c] ? STEP_WORD : STEP_BYTE); // [RL4]
          end
        end
      end
    end
  end

  // Single stolen cycle: one strobe with both addresses and the size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pec_valid    <= 1'b0;
      pec_chan     <= 3'h0;
      pec_src_addr <= '0;
      pec_dst_addr <= '0;
      pec_word     <= 1'b0;
    end else begin
      pec_valid <= pec_go; // [RL3]
      if (pec_go) begin
        pec_chan     <= pec_sel;
        pec_src_addr <= pc_sp[pec_sel];
        pec_dst_addr <= pc_dp[pec_sel];
        pec_word     <= pc_wrd[pec_sel];
      end
    end
  end

  // ****************************************************************
  // Configuration, status and interrupt line
  // ****************************************************************
  wire logic [15:0] stat_set = {ext_edge, 8'(pec_zero) << pec_sel};
  wire logic [15:0] stat_w1c = (wr_en & hit_stat) ? pwdata[15:0] : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel   <= `IPX_SRC_SEL_RESET; // [RL14]
      edge_mode <= `IPX_EDGE_MODE_RESET;
      status    <= `IPX_STATUS_RESET;
      mask      <= `IPX_MASK_RESET;
      irq       <= 1'b0;
    end else begin
      if (wr_en & hit_sel) begin
        src_sel <= pwdata[15:0]; // [RL12]
      end
      if (wr_en & hit_edge) begin
        edge_mode <= pwdata[15:0]; // [RL11]
      end
      if (wr_en & hit_mask) begin
        mask <= pwdata[15:0];
      end
      status <= (status & ~stat_w1c) | stat_set;
      irq    <= |(status & mask);
    end
  end

endmodule

// File: ipx_params.svh
// Offsets, field positions, reset values and timing counts of the interrupt block
`ifndef IPX_PARAMS_SVH
`define IPX_PARAMS_SVH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define IPX_IDX_SRC_SEL     16'hF1DA
`define IPX_IDX_EDGE_MODE   16'h0010
`define IPX_IDX_STATUS      16'h0011
`define IPX_IDX_MASK        16'h0012
`define IPX_IDX_SRC_BASE    16'h0100
`define IPX_IDX_PEC_BASE    16'h0200

// ****************************************************************
// Reset values and trap level
// ****************************************************************
`define IPX_SRC_SEL_RESET   16'h0000
`define IPX_EDGE_MODE_RESET 16'h0000
`define IPX_STATUS_RESET    16'h0000
`define IPX_MASK_RESET      16'h0000
`define IPX_TRAP_LEVEL      4'hF

// ****************************************************************
// Field positions
// ****************************************************************
`define IPX_CTRL_REQ        7
`define IPX_CTRL_EN         6
`define IPX_CTRL_LVL_MSB    3
`define IPX_PEC_CNT_MSB     7
`define IPX_PEC_WORD        8
`define IPX_PEC_INC_DST     9
`define IPX_PEC_CONT        10
`define IPX_PEC_EN          11
`define IPX_PEC_SRC_LSB     16
`define IPX_PEC_SRC_MSB     23
`define IPX_PEC_FLD_CTRL    2'h0
`define IPX_PEC_FLD_SRCP    2'h1
`define IPX_PEC_FLD_DSTP    2'h2

// ****************************************************************
// Source field and edge mode codes
// ****************************************************************
`define IPX_SS_PIN          2'h0
`define IPX_SS_ALT          2'h1
`define IPX_SS_OR           2'h2
`define IPX_SS_AND          2'h3
`define IPX_EDGE_RISE_BIT   0
`define IPX_EDGE_FALL_BIT   1

// ****************************************************************
// Response timing
// ****************************************************************
`define IPX_CLK_PERIOD_NS   10
`define IPX_RESP_MIN_NS     125
`define IPX_RESP_MAX_NS     300
`define IPX_RESP_MIN_CYC    ((`IPX_RESP_MIN_NS + `IPX_CLK_PERIOD_NS - 1) / `IPX_CLK_PERIOD_NS)
`define IPX_RESP_MAX_CYC    (`IPX_RESP_MAX_NS / `IPX_CLK_PERIOD_NS)

`endif

// File: ipx_pkg.sv
// Types shared by the interrupt block
package ipx_pkg;
  typedef enum logic [1:0] {
    IPX_IDLE,
    IPX_WAIT,
    IPX_OFFER
  } ipx_state_e;

  typedef logic [1:0] ipx_ss_t;
endpackage

// File: ipx_ext_sel.sv
// External interrupt input selection, synchronisation and edge detection
`timescale 1ns/1ps
`include "ipx_params.svh"

module ipx_ext_sel
  import ipx_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Asynchronous inputs
  input  wire logic [NUM_CH-1:0] pin,
  input  wire logic [NUM_CH-1:0] alt,
  // Configuration
  input  wire logic [2*NUM_CH-1:0] src_sel,
  input  wire logic [2*NUM_CH-1:0] edge_mode,
  // Detected edges
  output logic      [NUM_CH-1:0] edge_pulse
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic combine(input ipx_ss_t ss, input logic p, input logic a);
    logic r;
    case (ss)
      `IPX_SS_PIN: r = p;
      `IPX_SS_ALT: r = a;
      `IPX_SS_OR:  r = p | a;
      `IPX_SS_AND: r = p & a;
      default:     r = p;
    endcase
    return r;
  endfunction

  logic [NUM_CH-1:0] pin_s1;
  logic [NUM_CH-1:0] pin_s2;
  logic [NUM_CH-1:0] alt_s1;
  logic [NUM_CH-1:0] alt_s2;
  logic [NUM_CH-1:0] comb_d;
  logic [NUM_CH-1:0] comb_lvl;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [NUM_CH-1:0] edge_pulse_c;

  // Combining on synchronised levels keeps OR/AND free of metastable glitches
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      comb_lvl[i] = combine(src_sel[2*i +: 2], pin_s2[i], alt_s2[i]); // [RL12] [RL14]
    end
  end

  assign rise      = comb_lvl & ~comb_d;
  assign fall      = ~comb_lvl & comb_d;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      edge_pulse_c[i] = (edge_mode[2*i + `IPX_EDGE_RISE_BIT] & rise[i]) |
                        (edge_mode[2*i + `IPX_EDGE_FALL_BIT] & fall[i]); // [RL11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1     <= '0;
      pin_s2     <= '0;
      alt_s1     <= '0;
      alt_s2     <= '0;
      comb_d     <= '0;
      edge_pulse <= '0;
    end else begin
      pin_s1     <= pin;
      pin_s2     <= pin_s1;
      alt_s1     <= alt;
      alt_s2     <= alt_s1;
      comb_d     <= comb_lvl;
      edge_pulse <= edge_pulse_c;
    end
  end

endmodule

// File: ipx_cpu_model.sv
// CPU partner that accepts offered vectors promptly or slowly
`timescale 1ns/1ps
module ipx_cpu_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Offer handshake
  input  wire logic vec_valid,
  input  wire logic slow,
  output logic      vec_ack
);
  logic [1:0] held;
  // ****
  // Acceptance
  // ****
  // Slow acceptance proves that an offer stands until it is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {vec_ack, held} <= 3'h0;
    end else begin
      vec_ack <= vec_valid && !vec_ack && (!slow || held == 2'h3);
      held <= (vec_valid && !vec_ack) ? held + 2'h1 : 2'h0;
    end
  end
endmodule

// File: ipx_top_assertions.sv
// Port-level checks of the interrupt block
`timescale 1ns/1ps
module ipx_top_assertions (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // CPU side
  input wire logic [3:0]  cpu_level,
  input wire logic        vec_ack,
  input wire logic        vec_valid,
  input wire logic [6:0]  vec_num,
  input wire logic [3:0]  vec_level,
  input wire logic        vec_trap,
  input wire logic        pec_valid
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("lone error");
  chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write data out");
  chk_trap_level: assert property (vec_valid && vec_trap |-> vec_level == 4'hF)
    else $error("trap level");
  chk_offer_hold: assert property (vec_valid && !vec_ack |=> vec_valid && $stable(vec_num))
    else $error("offer moved");
  chk_ack_drop: assert property (vec_valid && vec_ack |=> !vec_valid)
    else $error("offer kept");
  chk_level_above: assert property ($rose(vec_valid) && !vec_trap |-> vec_level > $past(cpu_level))
    else $error("level too low");
  chk_offer_gap: assert property ($fell(vec_valid) |=> (!vec_valid || vec_trap) [*8])
    else $error("offer too soon");
  cov_trap: cover property (vec_valid && vec_trap);
  cov_pec: cover property (pec_valid);
  cov_err: cover property (pslverr);
endmodule

bind ipx_top ipx_top_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .cpu_level, .vec_ack, .vec_valid, .vec_num, .vec_level, .vec_trap, .pec_valid);

// File: testbench.sv
// Self-checking bench of the interrupt block
`timescale 1ns/1ps
`include "ipx_params.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl, slow, irq, trap_req, vec_ack;
  logic        first_can_receive_line, second_can_receive_line, vec_valid, vec_trap, pec_valid, pec_word, old;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ext_int_pin;
  logic [15:0] src_req;
  logic [3:0]  cpu_level, vec_level;
  logic [6:0]  trap_num, vec_num;
  logic [2:0]  pec_chan;
  logic [23:0] pec_src_addr, pec_dst_addr, sp, dp;
  int          error_cnt, cmp_count, cyc, seed, n, c, s, r, lv, ch, ss, em;

  ipx_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_int_pin, .first_can_receive_line, .second_can_receive_line, .src_req, .cpu_level, .trap_req,
    .trap_num, .vec_ack, .vec_valid, .vec_num, .vec_level, .vec_trap, .pec_valid, .pec_chan,
    .pec_src_addr, .pec_dst_addr, .pec_word, .irq);
  ipx_cpu_model cpu_u (.pclk, .presetn, .vec_valid, .slow, .vec_ack);

  // ****
  // Helpers
  // ****
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input int idx, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, 16'(idx), 2'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, sl} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic pulse(input logic [15:0] req, input logic t);
    while (vec_valid === 1'b1) @(posedge pclk);
    @(posedge pclk);
    {src_req, trap_req} <= {req, t};
    @(posedge pclk);
    {src_req, trap_req} <= 17'h0;
  endtask
  task automatic wait_vec();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (vec_valid !== 1'b1);
  endtask
  function automatic logic lvl();
    logic a = (ch == 0) ? first_can_receive_line : (ch == 1) & second_can_receive_line;
    logic p = ext_int_pin[ch];
    return (ss == 0) ? p : (ss == 1) ? a : (ss == 2) ? (p | a) : (p & a);
  endfunction

  // ****
  // Scenarios
  // ****
  initial begin
    seed = 56267;
    {psel, penable, pwrite, paddr, pwdata, src_req, cpu_level, trap_req, trap_num, slow} = '0;
    {ext_int_pin, first_can_receive_line, second_can_receive_line, presetn} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `IPX_IDX_SRC_SEL, 0);
    chk(rd, `IPX_SRC_SEL_RESET, "select");
    apb(0, 16'h0203, 0);
    chk({rd[30:0], sl}, 32'h1, "unmapped");
    apb(1, `IPX_IDX_MASK, 32'hFF);
    repeat (4) begin
      s = 8 + $unsigned($random(seed)) % 8;
      lv = 2 + $unsigned($random(seed)) % 14;
      slow <= 1'($random(seed));
      apb(1, `IPX_IDX_SRC_BASE + s, 32'h40 | lv);
      cpu_level <= 4'(lv - 1);
      pulse(16'h1 << s, 1'b0);
      wait_vec();
      chk(n >= 14 && n <= 31, 1, "latency");
      chk(vec_num, s, "vector");
      cpu_level <= 4'(lv);
      pulse(16'h1 << s, 1'b0);
      repeat (40) begin
        @(posedge pclk);
        chk(vec_valid, 0, "held");
      end
      cpu_level <= 4'h0;
      wait_vec();
      chk(vec_num, s, "pending");
      trap_num <= 7'($random(seed));
      pulse(16'h0, 1'b1);
      wait_vec();
      chk({n <= 4, vec_trap, vec_num}, {2'h3, trap_num}, "trap");
    end
    for (c = 0; c < 8; c++) begin
      s = 8 + c;
      r = $random(seed);
      sp = 24'($random(seed));
      dp = 24'($random(seed));
      apb(1, `IPX_IDX_SRC_BASE + s, 32'h41);
      apb(1, `IPX_IDX_PEC_BASE + 4 * c + 1, sp);
      apb(1, `IPX_IDX_PEC_BASE + 4 * c + 2, dp);
      apb(1, `IPX_IDX_PEC_BASE + 4 * c, (s << 16) | 32'h802 | (r & 32'h700));
      for (lv = 0; lv < 3; lv++) begin
        pulse(16'h1 << s, 1'b0);
        if (lv == 2 && !r[10]) begin
          wait_vec();
          chk(vec_num, s, "count zero");
        end else begin
          do @(posedge pclk); while (pec_valid !== 1'b1);
          chk({pec_chan, pec_word}, {3'(c), r[8]}, "channel");
          chk({pec_src_addr, pec_dst_addr}, {sp, dp}, "pointers");
          sp = sp + (r[9] ? 24'h0 : r[8] + 24'h1);
          dp = dp + (r[9] ? r[8] + 24'h1 : 24'h0);
        end
      end
      apb(0, `IPX_IDX_PEC_BASE + 4 * c, 0);
      chk({rd[7:0], irq}, r[10] ? 32'h4 : 32'h1, "count irq");
      apb(1, `IPX_IDX_STATUS, 32'h1 << c);
      apb(0, `IPX_IDX_STATUS, 0);
      chk({rd[7:0], irq}, 0, "cleared");
    end
    repeat (24) begin
      r = $random(seed);
      ch = $unsigned(r) % 3;
      ss = r[3:2];
      em = r[1:0];
      {ext_int_pin, first_can_receive_line, second_can_receive_line} <= r[15:6];
      apb(1, `IPX_IDX_SRC_SEL, ss << (2 * ch));
      apb(1, `IPX_IDX_EDGE_MODE, em << (2 * ch));
      repeat (6) @(posedge pclk);
      apb(1, `IPX_IDX_STATUS, 32'hFF00);
      old = lvl();
      {ext_int_pin, first_can_receive_line, second_can_receive_line} <= r[25:16];
      repeat (8) @(posedge pclk);
      apb(0, `IPX_IDX_STATUS, 0);
      chk({rd[8 + ch], irq}, {em[0] & lvl() & !old | em[1] & old & !lvl(), 1'b0}, "edge");
    end
    wrap_up();
  end
endmodule
